// [hdl/hrsp_pkg.sv]
// package: constants and types for the host register slave port
package hrsp_pkg;
  localparam int          HRSP_SEL_W       = 4;
  localparam int          HRSP_DATA_W      = 8;
  localparam int          HRSP_NREG        = 16;
  localparam int          HRSP_CLK_NS      = 100;
  // least spacing between device selects, in bus clocks
  localparam int          HRSP_CS_GAP_CLKS = 4;
  // fixed synchronisation wait after the strobes are seen
  localparam logic [1:0]  HRSP_SYNC_CLKS   = 2'h2;
  localparam logic [7:0]  HRSP_REG_RST     = 8'h00;
  localparam logic [3:0]  HRSP_SEL_RST     = 4'h0;

  typedef enum logic [2:0]
  {
    HRSP_IDLE = 3'b000,
    HRSP_SYNC = 3'b001,
    HRSP_HOLD = 3'b010,
    HRSP_ACK  = 3'b011,
    HRSP_DONE = 3'b100
  } hrsp_state_t;
endpackage

// [hdl/hrsp_if.sv]
// interface: synchronised host strobes between the pin stage and the port core
`timescale 1ns/1ns
interface hrsp_if;
  logic       cs;
  logic       rd;
  logic       wr;
  logic       als;
  logic [3:0] sel;
  logic [7:0] wdata;
  modport pins
  (
    output cs,
    output rd,
    output wr,
    output als,
    output sel,
    output wdata
  );
  modport core
  (
    input  cs,
    input  rd,
    input  wr,
    input  als,
    input  sel,
    input  wdata
  );
endinterface

// [hdl/hrsp_sync.sv]
// module: two-flop synchronisers for the host select, strobe, address and data pins (mux mode is not synchronised)
`timescale 1ns/1ns
module hrsp_sync
(
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // raw host pins
  input  wire logic                   i_cs_n,
  input  wire logic                   i_rd_n,
  input  wire logic                   i_wr_n,
  input  wire logic                   i_als,
  input  wire logic [3:0]             i_sel,
  input  wire logic [7:0]             i_wdata,
  // synchronised, active-high
  hrsp_if.pins                        sy
);
  import hrsp_pkg::*;

  logic [15:0] meta;
  logic [15:0] stab;

  // pins are asynchronous to the bus clock; first stage read only by second
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta <= 16'h0000;
      stab <= 16'h0000;
    end
    else
    begin
      meta <= {~i_cs_n, ~i_rd_n, ~i_wr_n, i_als, i_sel, i_wdata};
      stab <= meta;
    end
  end

  assign sy.cs    = stab[15];
  assign sy.rd    = stab[14];
  assign sy.wr    = stab[13];
  assign sy.als   = stab[12];
  assign sy.sel   = stab[11:8];
  assign sy.wdata = stab[7:0];
endmodule

// [hdl/hrsp_port.sv]
// module: host register slave port of the network controller
`timescale 1ns/1ns
// Operation
// [RULE1] device select low makes port a slave
// [RULE2] every transfer is one byte
// [RULE3] host uses four selects, read, write strobes
// [RULE4] latch select on address strobe if multiplexed
// [RULE5] hold acknowledge while local bus master
// [RULE6] synchronise access before acknowledging it
// [RULE7] host spaces device selects four clocks apart
// [RULE8] read ack after select and read low
// [RULE9] extra delay while DMA transfer finishes
// [RULE10] host waits until acknowledge goes low
// [RULE11] select and read strobe in either order
// [RULE12] decode register address only at acknowledge
// [RULE13] write ack after select and write low
// [RULE14] drive data only during acknowledged read
module hrsp_port
(
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  // host pins
  input  wire logic                          i_cs_n,
  input  wire logic                          i_slave_read_strobe_n,
  input  wire logic                          i_slave_write_strobe_n,
  input  wire logic                          i_address_latch_strobe,
  input  wire logic                          i_mux_mode,
  input  wire logic [hrsp_pkg::HRSP_SEL_W-1:0]  i_register_select_lines,
  input  wire logic [hrsp_pkg::HRSP_DATA_W-1:0] i_data,
  output logic      [hrsp_pkg::HRSP_DATA_W-1:0] o_data,
  output logic                               o_data_oe,
  output logic                               o_ack_n,
  // controller side
  input  wire logic                          i_dma_master,
  input  wire logic                          i_dma_busy,
  output logic                               o_cs_early
);
  import hrsp_pkg::*;

  // ******************************
  // synchronised pins
  // ******************************
  hrsp_if sy();

  hrsp_sync u_sync
  (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_cs_n  (i_cs_n),
    .i_rd_n  (i_slave_read_strobe_n),
    .i_wr_n  (i_slave_write_strobe_n),
    .i_als   (i_address_latch_strobe),
    .i_sel   (i_register_select_lines),
    .i_wdata (i_data),
    .sy      (sy)
  );

  // ******************************
  // state
  // ******************************
  hrsp_state_t                 state;
  hrsp_state_t                 next_state;
  logic [1:0]                  sync_cnt;
  logic [HRSP_SEL_W-1:0]       sel_latch;
  logic [HRSP_SEL_W-1:0]       sel_use;
  logic [HRSP_DATA_W-1:0]      regs [HRSP_NREG];
  logic                        access;

  // either strobe order accepted: only the combination matters
  // [RULE11] order-free access detect
  assign access = sy.cs & (sy.rd | sy.wr);

  // [RULE4] follow select while strobe high
  // value seen last before the strobe falls is held; select may settle late in the strobe
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sel_latch <= HRSP_SEL_RST;
    end
    else if (sy.als)
    begin
      sel_latch <= sy.sel;
    end
  end

  assign sel_use = i_mux_mode ? sel_latch : sy.sel;

  // ******************************
  // access sequencer
  // ******************************
  always_comb
  begin
    next_state = state;
    unique case (state)
      HRSP_IDLE:
      begin
        // [RULE1] slave only under select
        if (access)
        begin
          next_state = HRSP_SYNC;
        end
      end
      HRSP_SYNC:
      begin
        if (!access)
        begin
          next_state = HRSP_IDLE;
        end
        // [RULE6] fixed synchronisation wait
        else if (sync_cnt == HRSP_SYNC_CLKS)
        begin
          next_state = HRSP_HOLD;
        end
      end
      HRSP_HOLD:
      begin
        // [RULE5] wait out master mode
        // [RULE9] and any DMA in flight
        if (!access)
        begin
          next_state = HRSP_IDLE;
        end
        else if (!i_dma_master && !i_dma_busy)
        begin
          next_state = HRSP_ACK;
        end
      end
      HRSP_ACK:
      begin
        // [RULE14] release once strobe removed
        if (!(sy.rd | sy.wr))
        begin
          next_state = HRSP_DONE;
        end
      end
      HRSP_DONE:
      begin
        // wait for select release; avoids re-acking a held select
        if (!sy.cs)
        begin
          next_state = HRSP_IDLE;
        end
      end
      default:
      begin
        next_state = HRSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= HRSP_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync_cnt <= 2'h0;
    end
    else if (state == HRSP_SYNC)
    begin
      sync_cnt <= sync_cnt + 2'h1;
    end
    else
    begin
      sync_cnt <= 2'h0;
    end
  end

  // ******************************
  // acknowledge and data
  // ******************************
  // [RULE8] read ack after sync
  // [RULE13] write ack after sync
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_ack_n <= 1'b1;
    end
    else
    begin
      o_ack_n <= ~(next_state == HRSP_ACK);
    end
  end

  // [RULE12] decode only when acking
  // [RULE2] single byte per access
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < HRSP_NREG; i++)
      begin
        regs[i] <= HRSP_REG_RST;
      end
    end
    else if (state == HRSP_HOLD && next_state == HRSP_ACK && sy.wr)
    begin
      regs[sel_use] <= sy.wdata;
    end
  end

  // [RULE14] drive only during acked read
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_data    <= 8'h00;
      o_data_oe <= 1'b0;
    end
    else if (next_state == HRSP_ACK && sy.rd)
    begin
      o_data    <= regs[sel_use];
      o_data_oe <= 1'b1;
    end
    else
    begin
      o_data    <= 8'h00;
      o_data_oe <= 1'b0;
    end
  end

  // tells controller a host access is pending
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_cs_early <= 1'b0;
    end
    else
    begin
      o_cs_early <= access;
    end
  end
endmodule

// [verif/hrsp_port_monitor.sv]
// assertion checker for the host register slave port pins
`timescale 1ns/1ns
module hrsp_port_monitor
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // host pins
  input  wire logic       i_cs_n,
  input  wire logic       i_slave_read_strobe_n,
  input  wire logic       i_slave_write_strobe_n,
  input  wire logic [7:0] o_data,
  input  wire logic       o_data_oe,
  input  wire logic       o_ack_n,
  // controller side
  input  wire logic       i_dma_master,
  input  wire logic       i_dma_busy,
  input  wire logic       o_cs_early
);
  logic strb_off;
  assign strb_off = i_slave_read_strobe_n & i_slave_write_strobe_n;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ****
  // handshake
  // ****
  ack_cause_a: assert property ($fell(o_ack_n) |-> $past(!i_cs_n, 5) && $past(!strb_off, 5))
    else $error("ack without held select and strobe");
  dma_hold_a: assert property ($fell(o_ack_n) |-> !$past(i_dma_master) && !$past(i_dma_busy))
    else $error("ack given during dma");
  ack_stands_a: assert property (!o_ack_n && !strb_off |=> !o_ack_n)
    else $error("ack dropped while strobe held");
  ack_release_a: assert property (strb_off[*5] |-> o_ack_n)
    else $error("ack not released");
  cs_idle_a: assert property (i_cs_n[*6] |-> o_ack_n)
    else $error("ack without device select");
  // pending flag lags the pins by the two sync flops and its own register
  early_flag_a: assert property (o_cs_early == $past(!i_cs_n && !strb_off, 3))
    else $error("pending flag does not follow select and strobe");
  // ****
  // read data
  // ****
  oe_kind_a: assert property ($fell(o_ack_n) |-> o_data_oe == !i_slave_read_strobe_n)
    else $error("data drive does not match access kind");
  oe_ack_a: assert property (o_data_oe |-> !o_ack_n)
    else $error("data driven without ack");
  oe_zero_a: assert property (!o_data_oe |-> o_data == 8'h00)
    else $error("data not zero while idle");
  data_hold_a: assert property (o_data_oe && $past(o_data_oe) |-> $stable(o_data))
    else $error("read data changed during access");
endmodule

bind hrsp_port hrsp_port_monitor i_mon (.i_clk, .i_rst, .i_cs_n, .i_slave_read_strobe_n,
  .i_slave_write_strobe_n, .o_data, .o_data_oe, .o_ack_n, .i_dma_master, .i_dma_busy, .o_cs_early);

// [verif/hrsp_host_model.sv]
// host processor model driving the slave port pins
`timescale 1ns/1ns
module hrsp_host_model
(
  // clock
  input  wire logic       i_clk,
  // port pins
  input  wire logic       i_ack_n,
  input  wire logic [7:0] i_data,
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic            o_als,
  output logic [3:0]      o_sel,
  output logic [7:0]      o_data
);
  initial
  begin
    {o_cs_n, o_rd_n, o_wr_n, o_als} = 4'hE;
    o_sel = 4'h0;
    o_data = 8'h00;
  end
  // one byte access, strobes and data held until ack is sampled low; in mux mode select is inverted after the address strobe
  task automatic access(input logic rd, input logic [3:0] a, input logic [7:0] wd, input logic late,
                        input logic mx, output logic [7:0] rv, output logic ok);
    ok = 1'b0;
    o_sel = a;
    o_als = mx;
    repeat (3) @(posedge i_clk);
    #1;
    o_als = 1'b0;
    if (mx)
      o_sel = ~a;
    o_data = rd ? ~wd : wd;
    o_rd_n = !rd;
    o_wr_n = rd;
    o_cs_n = late;
    for (int n = 0; n < 200 && !ok; n++)
    begin
      @(posedge i_clk);
      #1;
      o_cs_n = 1'b0;
      ok = !i_ack_n;
    end
    @(posedge i_clk);
    #1;
    rv = i_data;
    {o_cs_n, o_rd_n, o_wr_n} = 3'h7;
    o_data = ~o_data;
    repeat (6) @(posedge i_clk);
    #1;
  endtask
endmodule

// [verif/hrsp_port_tb.sv]
// self-checking bench for the host register slave port
`timescale 1ns/1ns
module hrsp_port_tb;
  import hrsp_pkg::*;
  logic       clk, rst, cs_n, rd_n, wr_n, als, mux, dmam, dmab, oe, ack_n, ok, held;
  logic [3:0] sel;
  logic [7:0] hd, dd, rv, seed;
  int         bad_count, num_checks, mdl[16];

  hrsp_port i_dut
  (
    .i_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_slave_read_strobe_n(rd_n),
    .i_slave_write_strobe_n(wr_n), .i_address_latch_strobe(als), .i_mux_mode(mux),
    .i_register_select_lines(sel), .i_data(hd), .o_data(dd), .o_data_oe(oe), .o_ack_n(ack_n),
    .i_dma_master(dmam), .i_dma_busy(dmab), .o_cs_early()
  );
  hrsp_host_model i_host
  (
    .i_clk(clk), .i_ack_n(ack_n), .i_data(dd), .o_cs_n(cs_n), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_als(als), .o_sel(sel), .o_data(hd)
  );

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic c);
    num_checks++;
    if (c !== 1'b1)
    begin
      bad_count++;
      $display("unexpected at %0t: port differs from model", $time);
    end
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a timed-out access stops the sequence; the verdict is then reached once, at the end
  task automatic xfer(input logic rd, input logic [3:0] a, input logic [7:0] wd);
    i_host.access(rd, a, wd, a[0], mux, rv, ok);
    chk(ok);
    if (ok && rd)
      chk(rv === mdl[a][7:0]);
    else if (ok)
      mdl[a] = wd;
  endtask

  initial clk = 1'b0;
  always #50 clk = ~clk;
  // ****
  // sequence: reset reads, writes and reads in both select modes
  // ****
  initial
  begin
    rst = 1'b1;
    {mux, dmam, dmab} = 3'h0;
    seed = 8'h15;
    ok = 1'b1;
    foreach (mdl[i])
      mdl[i] = HRSP_REG_RST;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int k = 0; k < 5 && ok; k++)
    begin
      mux = k[1];
      // ack held off while either dma input is up
      for (int d = 0; d < 2 && k == 4 && ok; d++)
      begin
        {dmab, dmam} = d[0] ? 2'h2 : 2'h1;
        fork
          xfer(1'b0, 4'h5, 8'h5A);
          begin
            // ack must stay off over the whole window, not only at its end
            held = 1'b1;
            repeat (30)
            begin
              @(posedge clk);
              #1;
              held = held & (ack_n === 1'b1);
            end
            chk(held);
            {dmab, dmam} = 2'h0;
          end
        join
      end
      for (int a = 0; a < 16 && ok; a++)
      begin
        seed = lfsr(seed);
        xfer(!k[0], a[3:0], seed);
      end
    end
    wrap_up();
  end
endmodule
